// file: dv/i2cms_peer.sv
`timescale 1ns/1ps
// ------------------------------
// Behavioural slave on the wires
// ------------------------------
module i2cms_peer #(
  parameter logic [7:0] TX_BYTE = 8'ha5
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  output logic sda_pull
);
  int cnt = 0;
  logic first = 1'b1;
  logic rd = 1'b0;
  logic nk = 1'b1;
  logic [7:0] sh = 8'h00;
  initial sda_pull = 1'b0;
  // Start or repeated start opens a new frame
  always @(negedge sda) begin
    if (scl) begin
      cnt = 0;
      first = 1'b1;
      rd = 1'b0;
      sda_pull = 1'b0;
    end
  end
  // Shift on rising clock; the ninth bit records the master's answer
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    else nk = sda;
    cnt = cnt + 1;
  end
  // Change the drive only on the falling clock and hold it through the high phase; a NACK from the master frees the line
  always @(negedge scl) begin
    if (cnt == 8) sda_pull = (first || !rd) && ack_en;
    else if (cnt == 9) begin
      if (first) rd = sh[0];
      first = 1'b0;
      cnt = 0;
      sda_pull = rd && !nk && !TX_BYTE[7];
    end else sda_pull = rd && !first && !TX_BYTE[7 - cnt];
  end
endmodule : i2cms_peer

// file: dv/i2cms_sva.sv
`timescale 1ns/1ps
// ------------------------------
// Port checks of the bus core
// ------------------------------
module i2cms_sva
  import i2cms_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  logic en_r;
  logic ackd_r;
  wire acc = psel && penable;
  wire unm = (paddr > I2CMS_OFS_OWN) || (paddr[1:0] != 2'b00);
  wire ctl_wr = acc && pwrite && (paddr == I2CMS_OFS_CTRL);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of enable and ack value; only a landed write may change them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b0;
      ackd_r <= 1'b0;
    end else if (ctl_wr) begin
      en_r <= pwdata[CB_EN];
      ackd_r <= pwdata[CB_ACK_DATA_VALUE];
    end
  end
  // Request written with the module enabled
  sequence s_go(b);
    ctl_wr && pwdata[CB_EN] && pwdata[b];
  endsequence
  // Holding register read, then a status setup straight after
  sequence s_rx_stat;
    acc && !pwrite && (paddr == I2CMS_OFS_RXH) ##1
      psel && !penable && !pwrite && (paddr == I2CMS_OFS_STAT);
  endsequence
  property p_err; acc && unm |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error on unmapped access");
  property p_unm_rd; acc && unm && !pwrite |-> prdata == 32'h0000_0000; endproperty
  a_unm_rd: assert property (p_unm_rd) else $error("unmapped read not zero");
  property p_mask_hi;
    acc && !pwrite && (paddr == I2CMS_OFS_MASK) |-> prdata[15:10] == 6'h00;
  endproperty
  a_mask_hi: assert property (p_mask_hi) else $error("mask upper bits set");
  property p_rx_clr; s_rx_stat |=> !prdata[SB_RXF]; endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("rx full kept after read");
  property p_off; !en_r [*3] |-> !scl_oe && !sda_oe; endproperty
  a_off: assert property (p_off) else $error("lines driven while disabled");
  property p_begin;
    s_go(CB_BEGIN) ##0 (!scl_oe && !sda_oe) |-> ##[1:300] (sda_oe && !scl_oe);
  endproperty
  a_begin: assert property (p_begin) else $error("no start condition");
  property p_stop;
    s_go(CB_STOP) ##0 scl_oe |-> ##[1:300] ($fell(sda_oe) && !scl_oe);
  endproperty
  a_stop: assert property (p_stop) else $error("no stop condition");
  property p_ack;
    s_go(CB_ACKGO) ##0 scl_oe |-> ##[1:300] (!scl_oe && (sda_oe != ackd_r));
  endproperty
  a_ack: assert property (p_ack) else $error("wrong ack value on data");
endmodule : i2cms_sva

bind i2cms_core i2cms_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

// file: dv/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench import i2cms_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] d;
  logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, pull;
  int num_errors = 0;
  int checks_done = 0;
  // Open-drain wires with pull-ups
  wire scl_w = !scl_oe;
  wire sda_w = !(sda_oe || pull);
  always #2.5 pclk = ~pclk;
  i2cms_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
  i2cms_peer peer (.scl(scl_w), .sda(sda_w), .ack_en(1'b1), .sda_pull(pull));
  // ------------------------------
  // Bus tasks
  // ------------------------------
  // One transfer left standing, so another setup may follow at once
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] v);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, v};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
  endtask : xfer
  task automatic op(input logic w, input logic [7:0] a, input logic [15:0] v);
    xfer(w, a, v);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : op
  // Poll until a bit drops; a bit that sticks is left to the watchdog
  task automatic wait_clr(input logic [7:0] a, input int b);
    do op(1'b0, a, 16'h0000); while (d[b] !== 1'b0);
  endtask : wait_clr
  task automatic report_and_stop();
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    op(1'b0, I2CMS_OFS_STAT, 16'h0000);
    `CHK("stat_rst", 32'h0000_0000, d)
    op(1'b0, I2CMS_OFS_BAUD, 16'h0000);
    `CHK("baud_rst", {16'h0000, I2CMS_BAUD_RST}, d)
    op(1'b1, I2CMS_OFS_MASK, 16'hffff);
    op(1'b0, I2CMS_OFS_MASK, 16'h0000);
    `CHK("mask", 32'h0000_03ff, d)
    // A full mask would let the block answer its own frames as a slave
    op(1'b1, I2CMS_OFS_MASK, 16'h0000);
    op(1'b0, 8'h1c, 16'h0000);
    `CHK("unmapped", 32'h0000_0000, d)
    op(1'b1, I2CMS_OFS_BAUD, 16'h0003);
    // Write frame: start, address, then a second byte pushed while busy
    op(1'b1, I2CMS_OFS_CTRL, 16'h8001);
    wait_clr(I2CMS_OFS_CTRL, CB_BEGIN);
    repeat (4) @(posedge pclk);
    op(1'b0, I2CMS_OFS_STAT, 16'h0000);
    `CHK("start_seen", 2'b01, d[SB_STOP:SB_START])
    xfer(1'b1, I2CMS_OFS_TXH, 16'h00a2);
    xfer(1'b1, I2CMS_OFS_TXH, 16'h0055);
    op(1'b0, I2CMS_OFS_STAT, 16'h0000);
    `CHK("tx_busy", 3'b111, {d[SB_TXACT], d[SB_WCOL], d[SB_TXF]})
    wait_clr(I2CMS_OFS_STAT, SB_TXACT);
    `CHK("tx_done", 2'b00, {d[SB_ACK], d[SB_TXF]})
    op(1'b1, I2CMS_OFS_STAT, 16'hff7f);
    op(1'b0, I2CMS_OFS_STAT, 16'h0000);
    `CHK("wcol_clr", 1'b0, d[SB_WCOL])
    // Read frame: repeated start, read address, byte, ACK, byte, NACK, stop
    op(1'b1, I2CMS_OFS_CTRL, 16'h8002);
    wait_clr(I2CMS_OFS_CTRL, CB_RESTART);
    op(1'b1, I2CMS_OFS_TXH, 16'h00a3);
    wait_clr(I2CMS_OFS_STAT, SB_TXACT);
    op(1'b1, I2CMS_OFS_CTRL, 16'h8008);
    wait_clr(I2CMS_OFS_CTRL, CB_RXGO);
    op(1'b0, I2CMS_OFS_STAT, 16'h0000);
    `CHK("rx_full", 1'b1, d[SB_RXF])
    xfer(1'b0, I2CMS_OFS_RXH, 16'h0000);
    `CHK("rx_data", 32'h0000_00a5, d)
    op(1'b0, I2CMS_OFS_STAT, 16'h0000);
    `CHK("rx_empty", 1'b0, d[SB_RXF])
    op(1'b1, I2CMS_OFS_CTRL, 16'h8010);
    wait_clr(I2CMS_OFS_CTRL, CB_ACKGO);
    op(1'b1, I2CMS_OFS_CTRL, 16'h8008);
    wait_clr(I2CMS_OFS_CTRL, CB_RXGO);
    xfer(1'b0, I2CMS_OFS_RXH, 16'h0000);
    `CHK("rx_data2", 32'h0000_00a5, d)
    op(1'b1, I2CMS_OFS_CTRL, 16'h8030);
    wait_clr(I2CMS_OFS_CTRL, CB_ACKGO);
    op(1'b1, I2CMS_OFS_CTRL, 16'h8004);
    wait_clr(I2CMS_OFS_CTRL, CB_STOP);
    repeat (4) @(posedge pclk);
    op(1'b0, I2CMS_OFS_STAT, 16'h0000);
    `CHK("stop_seen", 2'b10, d[SB_STOP:SB_START])
    op(1'b1, I2CMS_OFS_CTRL, 16'h0000);
    repeat (4) @(posedge pclk);
    report_and_stop();
  end
  // Watchdog well beyond the thousand or so cycles the tests need
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
endmodule : testbench

// file: inc/i2cms_pkg.sv
package i2cms_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the APB bus
  // ----------------------------------------------------------------
  localparam logic [7:0] I2CMS_OFS_CTRL = 8'h00;
  localparam logic [7:0] I2CMS_OFS_STAT = 8'h04;
  localparam logic [7:0] I2CMS_OFS_MASK = 8'h08;
  localparam logic [7:0] I2CMS_OFS_TXH = 8'h0c;
  localparam logic [7:0] I2CMS_OFS_RXH = 8'h10;
  localparam logic [7:0] I2CMS_OFS_BAUD = 8'h14;
  localparam logic [7:0] I2CMS_OFS_OWN = 8'h18;

  // ----------------------------------------------------------------
  // bus_control field positions
  // ----------------------------------------------------------------
  localparam int CB_EN = 15;
  localparam int CB_ALL = 11;
  localparam int CB_A10 = 10;
  localparam int CB_GC = 7;
  localparam int CB_ACK_DATA_VALUE = 5;
  localparam int CB_ACKGO = 4;
  localparam int CB_RXGO = 3;
  localparam int CB_STOP = 2;
  localparam int CB_RESTART = 1;
  localparam int CB_BEGIN = 0;

  // ----------------------------------------------------------------
  // bus_status field positions
  // ----------------------------------------------------------------
  localparam int SB_ACK = 15;
  localparam int SB_TXACT = 14;
  localparam int SB_COL = 10;
  localparam int SB_GCS = 9;
  localparam int SB_TEN = 8;
  localparam int SB_WCOL = 7;
  localparam int SB_OVF = 6;
  localparam int SB_DA = 5;
  localparam int SB_STOP = 4;
  localparam int SB_START = 3;
  localparam int SB_DIR = 2;
  localparam int SB_RXF = 1;
  localparam int SB_TXF = 0;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [15:0] I2CMS_CTRL_RST = 16'h0000;
  localparam logic [15:0] I2CMS_CTRL_WMASK = 16'h8cbf;
  localparam logic [9:0] I2CMS_MASK_RST = 10'h000;
  localparam logic [9:0] I2CMS_OWN_RST = 10'h000;
  localparam logic [15:0] I2CMS_BAUD_RST = 16'h00f9;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {M_IDLE, M_START, M_RESTART, M_STOP, M_TX, M_RX, M_ACK} i2cms_mst_e;
  typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_ADDR2, SL_RX, SL_TX} i2cms_slv_e;

endpackage : i2cms_pkg

// file: rtl/i2cms_core.sv
// Behaviour
// - Acknowledge sequence drives ack_data_value on data: 1 is NACK, 0 is ACK.
// - ack_sequence_go starts acknowledge sequence; hardware clears it when finished.
// - master_receive_go receives one byte; cleared at end of eighth bit.
// - stop_request generates stop condition; cleared when stop sequence completes.
// - restart_request generates repeated start; cleared when sequence completes.
// - begin_request generates start condition; cleared when start sequence completes.
// - master_tx_active set at transmit start, cleared after slave acknowledge bit.
// - ten_bit_matched set on matched second address byte, cleared on stop.
// - Stop-seen flag shows stop was last bus condition; updates on each condition.
// - Start-seen flag shows start or restart was last bus condition.
// - Slave direction flag captures read/write bit of received address byte.
// - rx_full_flag sets on holding register load, clears on software read.
// - tx_full_flag sets on software write, clears when transmission completes.
// - Set address mask bits make matching incoming address bits don't-care.
// - Upper six address mask bits always read as zero.
// - General call address acknowledged only when general_call_accept is one; the code also acks it in accept_all_addr_mode.
// - Reserved addresses never match in slave mode, regardless of mask; the code matches them in accept_all_addr_mode, general call and ten-bit mode.
// - Masking applies only without accept_all_addr_mode; that mode acks everything.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module i2cms_core
  import i2cms_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  // ----------------------------------------------------------------
  // Pin synchronisers and bus condition detection
  // ----------------------------------------------------------------
  logic scl_s, sda_s, scl_d_r, sda_d_r;

  i2cms_sync #(.RST_VAL(1'b1)) u_scl_sync (.clk(pclk), .rst_n(presetn), .din(scl_in), .sync_r(scl_s));
  i2cms_sync #(.RST_VAL(1'b1)) u_sda_sync (.clk(pclk), .rst_n(presetn), .din(sda_in), .sync_r(sda_s));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [15:0] ctrl_r, baud_r, brg_cnt_r;
  logic [9:0] mask_r, own_r;
  logic [7:0] tx_hold_r, rx_hold_r, m_sh_r, sl_sh_r, sl_tx_sh_r;
  logic [31:0] prdata_r;
  logic ack_r, txact_r, col_r, gcs_r, ten_r, wcol_r, ovf_r, da_r;
  logic stop_r, start_r, dir_r, rx_full_r, tx_full_r;
  logic m_scl_low_r, m_sda_low_r, sl_ack_r, scl_oe_r, sda_oe_r;
  logic [1:0] m_ph_r;
  logic [3:0] m_bit_r, sl_cnt_r;
  i2cms_mst_e m_st_r;
  i2cms_slv_e sl_st_r;

  wire en = ctrl_r[CB_EN];

  // ----------------------------------------------------------------
  // APB decode; zero wait states, data registered in the setup cycle
  // ----------------------------------------------------------------
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_ctrl = paddr == I2CMS_OFS_CTRL;
  wire hit_stat = paddr == I2CMS_OFS_STAT;
  wire hit_mask = paddr == I2CMS_OFS_MASK;
  wire hit_txh = paddr == I2CMS_OFS_TXH;
  wire hit_rxh = paddr == I2CMS_OFS_RXH;
  wire hit_baud = paddr == I2CMS_OFS_BAUD;
  wire hit_own = paddr == I2CMS_OFS_OWN;
  wire mapped = hit_ctrl | hit_stat | hit_mask | hit_txh | hit_rxh | hit_baud | hit_own;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_r;

  wire [15:0] stat_w = {ack_r, txact_r, 3'b000, col_r, gcs_r, ten_r, wcol_r, ovf_r, da_r,
                        stop_r, start_r, dir_r, rx_full_r, tx_full_r};
  // Upper mask bits do not exist and read as zero
  wire [15:0] rd_mux = hit_ctrl ? ctrl_r :
                       hit_stat ? stat_w :
                       hit_mask ? {6'h00, mask_r} :
                       hit_txh ? {8'h00, tx_hold_r} :
                       hit_rxh ? {8'h00, rx_hold_r} :
                       hit_baud ? baud_r :
                       hit_own ? {6'h00, own_r} : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      prdata_r <= {16'h0000, rd_mux};
    end
  end

  // ----------------------------------------------------------------
  // Baud tick and master sequencing terms
  // ----------------------------------------------------------------
  wire tick = brg_cnt_r == 16'h0000;
  // A released clock that still reads low is being stretched; hold the phase
  wire adv = tick & ~(~m_scl_low_r & ~scl_s);
  wire m_tx = m_st_r == M_TX;
  wire m_rx = m_st_r == M_RX;
  wire m_bitst = m_tx | m_rx | (m_st_r == M_ACK);
  wire [1:0] m_fin_ph = (m_st_r == M_START || m_st_r == M_STOP) ? 2'd2 : 2'd3;
  wire [3:0] m_last = m_tx ? 4'd8 : m_rx ? 4'd7 : 4'd0;
  wire m_fin = adv & (m_st_r != M_IDLE) & (m_ph_r == m_fin_ph) & (~m_bitst | m_bit_r == m_last);
  // Released data reading low means another master won arbitration
  wire m_col = adv & ((m_tx & m_ph_r == 2'd1 & m_bit_r < 4'd8 & ~m_sda_low_r & ~sda_s) |
                      (m_st_r == M_START & m_ph_r == 2'd0 & ~sda_s));
  wire m_ack_smp = adv & m_tx & m_ph_r == 2'd1 & m_bit_r == 4'd8;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brg_cnt_r <= I2CMS_BAUD_RST;
    end else if (tick | m_st_r == M_IDLE) begin
      brg_cnt_r <= baud_r;
    end else begin
      brg_cnt_r <= brg_cnt_r - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Transmit write handling
  // ----------------------------------------------------------------
  wire tx_wr = wr & hit_txh;
  wire busy = (m_st_r != M_IDLE) | tx_full_r;
  wire wcol_set = tx_wr & busy;
  wire tx_load = tx_wr & ~busy;
  wire m_kick_tx = tx_load & en & (sl_st_r != SL_TX);

  // ----------------------------------------------------------------
  // Control register; a software write wins over a hardware clear
  // ----------------------------------------------------------------
  wire [15:0] hwclr = {11'h000,
                       m_col | (m_fin & m_st_r == M_ACK),
                       m_col | (m_fin & m_rx),
                       m_col | (m_fin & m_st_r == M_STOP),
                       m_col | (m_fin & m_st_r == M_RESTART),
                       m_col | (m_fin & m_st_r == M_START)};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= I2CMS_CTRL_RST;
      mask_r <= I2CMS_MASK_RST;
      own_r <= I2CMS_OWN_RST;
      baud_r <= I2CMS_BAUD_RST;
      tx_hold_r <= 8'h00;
    end else begin
      ctrl_r <= (wr & hit_ctrl) ? (pwdata[15:0] & I2CMS_CTRL_WMASK) : (ctrl_r & ~hwclr);
      if (wr & hit_mask) mask_r <= pwdata[9:0];
      if (wr & hit_own) own_r <= pwdata[9:0];
      if (wr & hit_baud) baud_r <= pwdata[15:0];
      if (tx_load) tx_hold_r <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Master sequencer: four baud phases per bit or restart, three per start or stop
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_st_r <= M_IDLE;
      m_ph_r <= 2'd0;
      m_bit_r <= 4'd0;
      m_sh_r <= 8'h00;
      m_scl_low_r <= 1'b0;
      m_sda_low_r <= 1'b0;
    end else if (!en | m_col) begin
      m_st_r <= M_IDLE;
      m_scl_low_r <= 1'b0;
      m_sda_low_r <= 1'b0;
    end else if (m_st_r == M_IDLE) begin
      m_ph_r <= 2'd0;
      m_bit_r <= 4'd0;
      if (ctrl_r[CB_BEGIN]) begin
        m_st_r <= M_START;
        m_scl_low_r <= 1'b0;
        m_sda_low_r <= 1'b0;
      end else if (ctrl_r[CB_RESTART]) begin
        m_st_r <= M_RESTART;
        m_sda_low_r <= 1'b0;
      end else if (ctrl_r[CB_STOP]) begin
        m_st_r <= M_STOP;
        m_sda_low_r <= 1'b1;
      end else if (ctrl_r[CB_RXGO]) begin
        m_st_r <= M_RX;
        m_scl_low_r <= 1'b1;
        m_sda_low_r <= 1'b0;
      end else if (ctrl_r[CB_ACKGO]) begin
        m_st_r <= M_ACK;
        m_scl_low_r <= 1'b1;
        m_sda_low_r <= ~ctrl_r[CB_ACK_DATA_VALUE];
      end else if (m_kick_tx) begin
        m_st_r <= M_TX;
        m_scl_low_r <= 1'b1;
        m_sda_low_r <= ~pwdata[7];
        m_sh_r <= pwdata[7:0];
      end
    end else if (adv) begin
      m_ph_r <= m_ph_r + 2'd1;
      if (m_fin) m_st_r <= M_IDLE;
      case (m_st_r)
        M_START: begin
          if (m_ph_r == 2'd0) m_sda_low_r <= 1'b1;
          if (m_ph_r == 2'd1) m_scl_low_r <= 1'b1;
        end
        M_RESTART: begin
          if (m_ph_r == 2'd0) m_scl_low_r <= 1'b0;
          if (m_ph_r == 2'd1) m_sda_low_r <= 1'b1;
          if (m_ph_r == 2'd2) m_scl_low_r <= 1'b1;
        end
        M_STOP: begin
          if (m_ph_r == 2'd0) m_scl_low_r <= 1'b0;
          if (m_ph_r == 2'd1) m_sda_low_r <= 1'b0;
        end
        default: begin
          if (m_ph_r == 2'd0) m_scl_low_r <= 1'b0;
          if (m_ph_r == 2'd1 && m_rx) m_sh_r <= {m_sh_r[6:0], sda_s};
          if (m_ph_r == 2'd2) m_scl_low_r <= 1'b1;
          if (m_ph_r == 2'd3) begin
            m_bit_r <= m_bit_r + 4'd1;
            if (m_tx) m_sh_r <= {m_sh_r[6:0], 1'b0};
            // Next data bit, or release for the acknowledge and at the end
            m_sda_low_r <= m_tx & ~m_fin & (m_bit_r < 4'd7) & ~m_sh_r[6];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Slave address matching
  // ----------------------------------------------------------------
  wire all_mode = ctrl_r[CB_ALL];
  wire ten_mode = ctrl_r[CB_A10];
  wire [6:0] a7 = sl_sh_r[7:1];
  wire sl_rw = sl_sh_r[0];
  wire rsv = (a7[6:3] == 4'b0000) | (a7[6:3] == 4'b1111);
  wire m7 = ((a7 ^ own_r[6:0]) & ~mask_r[6:0]) == 7'h00;
  wire ten_hi = (a7[6:2] == 5'b11110) & (((a7[1:0] ^ own_r[9:8]) & ~mask_r[9:8]) == 2'b00);
  wire lo_m = ((sl_sh_r ^ own_r[7:0]) & ~mask_r[7:0]) == 8'h00;
  wire gc_hit = ctrl_r[CB_GC] & (sl_sh_r == 8'h00);
  // Accept-all acknowledges everything and bypasses the mask
  wire a_ok7 = all_mode | gc_hit | (~ten_mode & ~rsv & m7);
  wire a_hi = ~all_mode & ~gc_hit & ten_mode & ten_hi & (~sl_rw | ten_r);
  wire addr_ok = a_ok7 | a_hi;
  wire in_addr = sl_st_r == SL_ADDR;
  wire in_addr2 = sl_st_r == SL_ADDR2;
  wire in_srx = sl_st_r == SL_RX;
  wire in_stx = sl_st_r == SL_TX;
  wire sl_ack_ok = in_addr ? addr_ok : in_addr2 ? lo_m : in_srx & ~rx_full_r;
  wire sl_dec = scl_fall & (sl_cnt_r == 4'd8) & (in_addr | in_addr2 | in_srx);
  wire sl_ack_smp = scl_rise & in_stx & (sl_cnt_r == 4'd8);
  wire sl_txld = scl_fall & in_stx & (sl_cnt_r == 4'd9);
  i2cms_slv_e sl_nxt;
  assign sl_nxt = in_addr ? (!addr_ok ? SL_IDLE : (a_hi & ~sl_rw) ? SL_ADDR2 :
                             sl_rw ? SL_TX : SL_RX) :
                  in_addr2 ? (lo_m ? SL_RX : SL_IDLE) : sl_st_r;

  // ----------------------------------------------------------------
  // Slave byte engine, clocked by sampled bus clock edges
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sl_st_r <= SL_IDLE;
      sl_cnt_r <= 4'd0;
      sl_sh_r <= 8'h00;
      sl_tx_sh_r <= 8'h00;
      sl_ack_r <= 1'b0;
    end else if (!en | stop_det) begin
      sl_st_r <= SL_IDLE;
      sl_cnt_r <= 4'd0;
      sl_ack_r <= 1'b0;
    end else if (start_det) begin
      sl_st_r <= SL_ADDR;
      sl_cnt_r <= 4'd0;
      sl_ack_r <= 1'b0;
    end else if (scl_rise & sl_st_r != SL_IDLE) begin
      if (sl_cnt_r < 4'd8) sl_sh_r <= {sl_sh_r[6:0], sda_s};
      sl_cnt_r <= sl_cnt_r + 4'd1;
      if (sl_ack_smp & sda_s) sl_st_r <= SL_IDLE;
    end else if (scl_fall & sl_st_r != SL_IDLE) begin
      if (sl_cnt_r == 4'd8) begin
        sl_ack_r <= sl_ack_ok;
        sl_st_r <= sl_nxt;
      end else if (sl_cnt_r == 4'd9) begin
        sl_ack_r <= 1'b0;
        sl_cnt_r <= 4'd0;
        if (in_stx) sl_tx_sh_r <= tx_hold_r;
      end else if (in_stx) begin
        sl_tx_sh_r <= {sl_tx_sh_r[6:0], 1'b0};
      end
    end
  end

  wire sl_low = sl_ack_r | (in_stx & sl_cnt_r < 4'd8 & ~sl_tx_sh_r[7]);

  // ----------------------------------------------------------------
  // Status flags; every hardware set wins over a same-cycle clear
  // ----------------------------------------------------------------
  wire sclr = wr & hit_stat;
  wire rx_try_m = m_fin & m_rx;
  wire rx_try_s = sl_dec & in_srx;
  wire rx_ld = (rx_try_m | rx_try_s) & ~rx_full_r;
  wire rx_rd = rd & hit_rxh;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ack_r, txact_r, col_r, gcs_r, ten_r, wcol_r, ovf_r, da_r} <= 8'h00;
      {stop_r, start_r, dir_r, rx_full_r, tx_full_r} <= 5'h00;
      rx_hold_r <= 8'h00;
    end else begin
      if (m_ack_smp | sl_ack_smp) ack_r <= sda_s;
      txact_r <= m_kick_tx | (txact_r & ~(m_fin & m_tx) & ~m_col);
      col_r <= m_col | (col_r & ~(sclr & ~pwdata[SB_COL]));
      wcol_r <= wcol_set | (wcol_r & ~(sclr & ~pwdata[SB_WCOL]));
      ovf_r <= ((rx_try_m | rx_try_s) & rx_full_r) | (ovf_r & ~(sclr & ~pwdata[SB_OVF]));
      if (sl_dec & in_addr) gcs_r <= gc_hit;
      else if (stop_det) gcs_r <= 1'b0;
      ten_r <= (sl_dec & in_addr2 & lo_m) | (ten_r & ~stop_det);
      if (sl_dec & in_addr & addr_ok) dir_r <= sl_rw;
      if (sl_dec & in_addr & addr_ok) da_r <= 1'b0;
      else if (rx_try_s) da_r <= 1'b1;
      if (start_det | stop_det) begin
        stop_r <= stop_det;
        start_r <= start_det;
      end
      rx_full_r <= rx_ld | (rx_full_r & ~rx_rd);
      if (rx_ld) rx_hold_r <= rx_try_m ? m_sh_r : sl_sh_r;
      tx_full_r <= tx_load | (tx_full_r & ~((m_fin & m_tx) | sl_txld | m_col));
    end
  end

  // ----------------------------------------------------------------
  // Open-drain pin drive; outputs only ever pull low
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      scl_oe_r <= en & m_scl_low_r;
      sda_oe_r <= en & (m_sda_low_r | sl_low);
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;

endmodule : i2cms_core

// file: rtl/i2cms_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser; only the second stage is visible outside
module i2cms_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic sync_r
);
  logic meta_r;

  // First stage may go metastable, so nothing but the second stage reads it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end
endmodule : i2cms_sync
